/* File: bench/delayed_trigger_sequencer_tb.sv */
// self-checking bench for the delayed trigger sequencer
// assumes the partner model feeds primary triggers and sample strobes
`timescale 1ns/10ps
`include "dts_regs.vh"
module delayed_trigger_sequencer_tb;
  logic               clk, reset_n, psel, penable, pwrite, slow, fire, auxPin, rerr;
  logic        [11:0] paddr;
  logic        [31:0] pwdata, prdata, rdat;
  logic               pready, pslverr, storeSample, postTrigger, recordReady, acqStart;
  logic               primaryTrigger, sampleStrobe;
  logic        [3:0]  channelPin;
  logic        [2:0]  secSource;
  logic        [1:0]  secCoupling;
  logic signed [15:0] peakLevel, secLevel, primaryLevel, lvl;
  logic        [7:0]  postCount;
  int                 n_fail, checked, acqSeen, stSeen, n, d, a0;
  localparam logic [31:0] PRI [5] = '{32'h0, 32'h1, 32'hA, 32'hE, 32'h40};
  dts_sequencer dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .channelPin(channelPin), .dcAuxiliaryInputPin(auxPin),
    .primaryTrigger(primaryTrigger), .sampleStrobe(sampleStrobe), .peakLevel(peakLevel),
    .storeSample(storeSample), .postTrigger(postTrigger), .recordReady(recordReady),
    .acqStart(acqStart), .secSource(secSource), .secCoupling(secCoupling),
    .secLevel(secLevel), .primaryLevel(primaryLevel));
  dts_partner_model partner (.clk(clk), .reset_n(reset_n), .slow(slow), .fire(fire),
    .storeSample(storeSample), .postTrigger(postTrigger),
    .primaryTrigger(primaryTrigger), .sampleStrobe(sampleStrobe), .postCount(postCount));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (acqStart === 1'b1) acqSeen <= acqSeen + 1;
    if (storeSample === 1'b1) stSeen <= stSeen + 1;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task cyc(input int c);
    repeat (c) @(posedge clk);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk);
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  task pin(input int c, input logic v);
    channelPin[c] <= v;
    cyc(8);
  endtask
  task arm_fire();
    apb(1'b1, `DTS_CMD_OFF, 32'h1);
    a0 = stSeen;
    cyc(12);
    chk(stSeen > a0, 1'b1); // pre samples stored
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
  endtask
  task rec_done();
    n = 0;
    while (recordReady !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    chk(postCount, 8'h04); // post fill count
  endtask
  function automatic logic [15:0] lexp(int s, int f, int p, int m);
    int v;
    v = (s == 0) ? f : (s == 1) ? 1400 : (s == 2) ? -1300 : p / 2;
    if (v > 12 * m) v = 12 * m;
    if (v < -12 * m) v = -12 * m;
    return 16'(v);
  endfunction
  task tally_and_finish();
    $display("compares %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #(50 * 40000);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    n_fail = 0;
    checked = 0;
    acqSeen = 0;
    stSeen = 0;
    reset_n = 1'b0;
    {psel, penable, pwrite, slow, fire, auxPin} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    channelPin = 4'h0;
    peakLevel = 16'h0000;
    void'($urandom(74));
    repeat (16) @(posedge clk);
    chk(secCoupling, `DTS_CPL_DC);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(`DTS_CTRL_OFF, `DTS_CTRL_RST);
    rd(`DTS_DELAY_OFF, `DTS_DELAY_RST);
    rd(`DTS_RECORD_OFF, `DTS_RECORD_RST);
    apb(1'b0, 12'h040, 32'h0);
    chk(rerr, 1'b1);
    apb(1'b1, `DTS_RECORD_OFF, 32'h0008_0004);
    for (int i = 0; i < 5; i++) begin
      d = 5 + $urandom % 20;
      slow <= i[0];
      apb(1'b1, `DTS_PRIMARY_OFF, PRI[i]);
      apb(1'b1, `DTS_CTRL_OFF, (i == 0) ? 32'h0 : 32'h3);
      apb(1'b1, `DTS_DELAY_OFF, d);
      rd(`DTS_ZONE_OFF, {16'(d + 4), 16'(d - 4)});
      apb(1'b0, `DTS_CTRL_OFF, 32'h0);
      chk(rdat[0], 1'b0);
      arm_fire();
      a0 = acqSeen;
      n = 0;
      while (acqSeen == a0 && n < 200) begin
        @(posedge clk);
        n++;
      end
      chk(n >= d && n <= d + 8, 1'b1);
      rec_done();
    end
    apb(1'b1, `DTS_PRIMARY_OFF, 32'h0);
    for (int i = 0; i < 3; i++) begin
      d = $urandom % 5;
      n = 1 + $urandom % 2;
      apb(1'b1, `DTS_PRIMARY_OFF, n << 8);
      apb(1'b1, `DTS_CTRL_OFF, (i << 8) | (d << 4) | 32'h2);
      cyc(4);
      chk(secSource, d[2:0]);
      chk(secCoupling, (i == 0) ? n[1:0] : i[1:0]);
      apb(1'b0, `DTS_CTRL_OFF, 32'h0);
      chk(rdat[0], 1'b1);
    end
    apb(1'b1, `DTS_PRIMARY_OFF, 32'h0);
    for (int i = 0; i < 8; i++) begin
      d = i[0] ? 100 : 200;
      n = $urandom % 4000;
      lvl = 16'(n - 2000);
      peakLevel <= 16'($urandom % 3000);
      apb(1'b1, `DTS_LEVEL_OFF, {d[11:0], 4'h0, lvl});
      apb(1'b1, `DTS_CTRL_OFF, (i >> 1) << 12);
      cyc(4);
      chk(secLevel[15:0], lexp(i >> 1, lvl, peakLevel, d));
    end
    apb(1'b1, `DTS_PRIMARY_OFF, 32'h40);
    apb(1'b1, `DTS_CTRL_OFF, 32'h40);
    apb(1'b1, `DTS_LEVEL_OFF, {12'h0C8, 4'h1, 16'h02BC});
    cyc(4);
    chk(secLevel[15:0], 16'h02BC);
    apb(1'b1, `DTS_LEVEL_OFF, {12'h0C8, 4'h0, 16'hFE0C});
    cyc(4);
    chk(primaryLevel[15:0], 16'hFE0C);
    apb(1'b1, `DTS_PRIMARY_OFF, 32'h0);
    for (int s = 0; s < 2; s++) begin
      n = 2 + $urandom % 3;
      d = $urandom % 4;
      slow <= 1'b1;
      apb(1'b1, `DTS_EVENTS_OFF, n);
      apb(1'b1, `DTS_CTRL_OFF, (s << 10) | (d << 4) | 32'h104);
      arm_fire();
      a0 = acqSeen;
      repeat (n - 1) begin
        pin(d, 1'b1);
        pin(d, 1'b0);
      end
      pin(d, 1'b1);
      chk(acqSeen - a0, 1 - s);
      pin(d, 1'b0);
      chk(acqSeen - a0, 1);
      rec_done();
    end
    d = 30 + $urandom % 20;
    apb(1'b1, `DTS_DELAY_OFF, d);
    apb(1'b1, `DTS_EVENTS_OFF, 32'h7);
    rd(`DTS_DELAY_OFF, d);
    apb(1'b1, `DTS_CTRL_OFF, 32'h102);
    rd(`DTS_ZONE_OFF, {16'hFFFF, 16'(d - 4)});
    arm_fire();
    a0 = acqSeen;
    pin(0, 1'b1);
    pin(0, 1'b0);
    chk(acqSeen - a0, 0);
    cyc(d);
    pin(0, 1'b1);
    chk(acqSeen - a0, 1);
    pin(0, 1'b0);
    rec_done();
    apb(1'b1, `DTS_EVENTS_OFF, 32'h2);
    apb(1'b1, `DTS_CTRL_OFF, 32'h106);
    arm_fire();
    a0 = acqSeen;
    repeat (2) begin
      pin(0, 1'b1);
      pin(0, 1'b0);
    end
    chk(acqSeen - a0, 0);
    cyc(d);
    pin(0, 1'b1);
    chk(acqSeen - a0, 1);
    pin(0, 1'b0);
    rec_done();
    tally_and_finish();
  end
endmodule // delayed_trigger_sequencer_tb

/* File: bench/dts_checker_properties.sv */
// concurrent checks on the apb handshake and the acquisition outputs
// assumes it is bound into dts_sequencer, one clock domain
`timescale 1ns/10ps
module dts_checker_properties (
  input wire clk,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire sampleStrobe,
  input wire storeSample,
  input wire postTrigger,
  input wire recordReady,
  input wire acqStart
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_open;
    psel && penable && !$past(penable);
  endsequence
  sequence s_post;
    ##[0:3] postTrigger;
  endsequence
  sequence s_ready;
    ##[0:2] recordReady;
  endsequence
  a_ready_timing: assert property (s_open |=> pready)
    else $error("pready late in access");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held two cycles");
  a_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  a_err_paired: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_start_pulse: assert property (acqStart |=> !acqStart)
    else $error("acqStart wider than one cycle");
  a_start_capture: assert property (acqStart |-> s_post)
    else $error("no post capture after start");
  a_post_ready: assert property ($fell(postTrigger) |-> s_ready)
    else $error("record not ready after capture");
  a_store_strobe: assert property (storeSample |-> $past(sampleStrobe))
    else $error("store without sample strobe");
endmodule // dts_checker_properties

bind dts_sequencer dts_checker_properties u_props (.clk(clk), .reset_n(reset_n),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .sampleStrobe(sampleStrobe), .storeSample(storeSample), .postTrigger(postTrigger),
  .recordReady(recordReady), .acqStart(acqStart));

/* File: bench/dts_partner_model.sv */
// primary trigger source and record controller model
// assumes fire is a one-cycle request from the bench on clk
`timescale 1ns/10ps
module dts_partner_model (
  input  wire       clk,
  input  wire       reset_n,
  input  wire       slow,
  input  wire       fire,
  input  wire       storeSample,
  input  wire       postTrigger,
  output reg        primaryTrigger,
  output reg        sampleStrobe,
  output reg  [7:0] postCount
);
  reg [2:0] div;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div <= 3'h0;
      primaryTrigger <= 1'b0;
      sampleStrobe <= 1'b0;
      postCount <= 8'h00;
    end else begin
      primaryTrigger <= fire;
      div <= (div >= (slow ? 3'h4 : 3'h1)) ? 3'h0 : div + 3'h1;
      sampleStrobe <= (div == 3'h0);
      if (fire) begin
        postCount <= 8'h00;
      end else if (storeSample && postTrigger) begin
        postCount <= postCount + 8'h01;
      end
    end
  end
endmodule // dts_partner_model

/* File: include/dts_regs.vh */
// register map, field positions, reset values and level presets of the
// delayed trigger sequencer; assumes a 32-bit apb slave, 20 MHz clock
`ifndef DTS_REGS_VH
`define DTS_REGS_VH

// byte offsets
`define DTS_CTRL_OFF      12'h000
`define DTS_DELAY_OFF     12'h004
`define DTS_EVENTS_OFF    12'h008
`define DTS_PRIMARY_OFF   12'h00C
`define DTS_LEVEL_OFF     12'h010
`define DTS_RECORD_OFF    12'h014
`define DTS_STATUS_OFF    12'h018
`define DTS_ZONE_OFF      12'h01C
`define DTS_CMD_OFF       12'h020

// control fields
`define DTS_CTRL_TRIGGERABLE 0
`define DTS_CTRL_SUB_LSB     1
`define DTS_CTRL_SRC_LSB     4
`define DTS_CTRL_CPL_LSB     8
`define DTS_CTRL_SLOPE       10
`define DTS_CTRL_LVLSEL_LSB  12

// primary setting fields
`define DTS_PRI_TYPE_LSB     0
`define DTS_PRI_CLASS_LSB    2
`define DTS_PRI_SRC_LSB      4
`define DTS_PRI_CPL_LSB      8

// encodings
`define DTS_SUB_NONE      2'h0
`define DTS_SUB_TIME      2'h1
`define DTS_SUB_EVENTS    2'h2
`define DTS_SUB_EVTIME    2'h3
`define DTS_SRC_AUX       3'h4
`define DTS_CPL_FOLLOW    2'h0
`define DTS_CPL_DC        2'h1
`define DTS_CPL_NOISE     2'h2
`define DTS_TYPE_EDGE     2'h0
`define DTS_TYPE_LOGIC    2'h1
`define DTS_TYPE_PULSE    2'h2
`define DTS_CLASS_RUNT    2'h2
`define DTS_CLASS_SLEW    2'h3
`define DTS_LVL_FREE      2'h0
`define DTS_LVL_TTL       2'h1
`define DTS_LVL_ECL       2'h2
`define DTS_LVL_HALF      2'h3

// levels in millivolts and range in divisions, signed 16 bit
`define DTS_TTL_MV        16'h0578
`define DTS_ECL_MV        16'hFAEC
`define DTS_RANGE_DIVS    16'h000C

// reset values
`define DTS_CTRL_RST      32'h0000_0000
`define DTS_DELAY_RST     32'h0000_0001
`define DTS_EVENTS_RST    16'h0001
`define DTS_PRI_RST       32'h0000_0000
`define DTS_LEVEL_RST     16'h0000
`define DTS_RECORD_RST    32'h0020_0010
`define DTS_PRE_RST       16'h0010
`define DTS_TOTAL_RST     16'h0020
`define DTS_MVDIV_RST     12'h064

`endif

/* File: rtl/dts_edge_detect.v */
// edge qualifier for the secondary source
// assumes the sampled source level is already on the clk domain
`timescale 1ns/10ps
module dts_edge_detect (
  input  wire clk,
  input  wire reset_n,
  input  wire level,
  input  wire falling,
  output reg  edgeHit
);
  reg last;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      last    <= 1'b0;
      edgeHit <= 1'b0;
    end else begin
      last <= level;
      // R15 slope select
      edgeHit <= falling ? (last & ~level) : (~last & level);
    end
  end
endmodule // dts_edge_detect

/* File: rtl/dts_level_clamp.v */
// resolves the secondary trigger level and clamps it to the range
// assumes volts per division in millivolts from the register file
`timescale 1ns/10ps
`include "dts_regs.vh"
module dts_level_clamp (
  input  wire        [1:0]  levelSel,
  input  wire signed [15:0] freeLevel,
  input  wire signed [15:0] peakLevel,
  input  wire        [11:0] mvPerDiv,
  output reg  signed [15:0] level
);
  reg signed [15:0] raw;
  reg signed [27:0] lim;

  always @* begin
    // R16 preset levels
    case (levelSel)
      `DTS_LVL_TTL:  raw = `DTS_TTL_MV;
      `DTS_LVL_ECL:  raw = `DTS_ECL_MV;
      `DTS_LVL_HALF: raw = peakLevel >>> 1;
      default:       raw = freeLevel;
    endcase
    lim = $signed({16'h0000, mvPerDiv}) * $signed({12'h000, `DTS_RANGE_DIVS});
    if (lim > 28'sh0007FFF)
      lim = 28'sh0007FFF;
    // R17 range clamp
    if ($signed({{12{raw[15]}}, raw}) > lim)
      level = lim[15:0];
    else if ($signed({{12{raw[15]}}, raw}) < -lim)
      level = -lim[15:0];
    else
      level = raw;
  end
endmodule // dts_level_clamp

/* File: rtl/dts_sequencer.v */
// delayed trigger sequencer with apb register file
// assumes primary trigger and sample strobes on clk, source pins asynchronous
//
// Overview of operation
// R1: two delay modes; only triggerable uses secondary trigger logic
// R2: wait-then-run: primary trigger, delay expires, acquisition starts
// R3: triggerable qualifies by time, events, or events then time
// R4: pre-trigger samples stored continuously while waiting
// R5: after criteria, capture remaining post samples then flag record ready
// R6: logic type or runt/slew pulse forces wait-then-run
// R7: triggerable selection refused while primary setting incompatible
// R8: wait-then-run zone spans the secondary record exactly
// R9: triggerable zone from earliest start to end of primary record
// R10: choosing any triggerable sub-mode sets triggerable mode
// R11: combined sub-mode keeps delay and count as separate settings
// R12: source is one of four channels or dc auxiliary input
// R13: both on dc auxiliary input keeps the two levels equal
// R14: coupling follow-primary, dc or noise-reject
// R15: fires on selected rising or falling edge
// R16: level free, ttl +1.4 V, ecl -1.3 V, or half peak-to-peak
// R17: level clamped to twelve divisions from centre; when tandem, secLevel takes primaryLevel unclamped
// R18: event sub-mode triggers on the edge reaching the count
// R19: time sub-mode times delay then triggers on next edge
`timescale 1ns/10ps
`include "dts_regs.vh"
module dts_sequencer (
  input  wire               clk,
  input  wire               reset_n,
  input  wire               psel,
  input  wire               penable,
  input  wire               pwrite,
  input  wire        [11:0] paddr,
  input  wire        [31:0] pwdata,
  output reg         [31:0] prdata,
  output reg                pready,
  output reg                pslverr,
  input  wire        [3:0]  channelPin,
  input  wire               dcAuxiliaryInputPin,
  input  wire               primaryTrigger,
  input  wire               sampleStrobe,
  input  wire signed [15:0] peakLevel,
  output reg                storeSample,
  output reg                postTrigger,
  output reg                recordReady,
  output reg                acqStart,
  output reg         [2:0]  secSource,
  output reg         [1:0]  secCoupling,
  output reg  signed [15:0] secLevel,
  output reg  signed [15:0] primaryLevel
);
  localparam IDLE = 3'h0;
  localparam PRE  = 3'h1;
  localparam CNT  = 3'h2;
  localparam TIM  = 3'h3;
  localparam ARM  = 3'h4;
  localparam POST = 3'h5;
  localparam DONE = 3'h6;

  reg        [31:0] ctrl;
  reg        [31:0] delayTime;
  reg        [15:0] eventCount;
  reg        [31:0] primary;
  reg signed [15:0] freeLevel;
  reg        [11:0] mvPerDiv;
  reg        [15:0] preLen;
  reg        [15:0] recLen;
  reg        [2:0]  state;
  reg        [31:0] timer;
  reg        [15:0] evCnt;
  reg        [15:0] sampCnt;
  reg        [31:0] trigAt;
  reg        [31:0] zoneStart;
  reg        [31:0] zoneEnd;
  reg        [4:0]  pinMeta;
  reg        [4:0]  pinSync;
  reg               armPending;

  wire [1:0] subMode = ctrl[`DTS_CTRL_SUB_LSB+1:`DTS_CTRL_SUB_LSB];
  wire [2:0] srcSel  = ctrl[`DTS_CTRL_SRC_LSB+2:`DTS_CTRL_SRC_LSB];
  wire [1:0] cplSel  = ctrl[`DTS_CTRL_CPL_LSB+1:`DTS_CTRL_CPL_LSB];
  wire [1:0] priType = primary[`DTS_PRI_TYPE_LSB+1:`DTS_PRI_TYPE_LSB];
  wire [1:0] priCls  = primary[`DTS_PRI_CLASS_LSB+1:`DTS_PRI_CLASS_LSB];
  wire [2:0] priSrc  = primary[`DTS_PRI_SRC_LSB+2:`DTS_PRI_SRC_LSB];
  wire [1:0] priCpl  = primary[`DTS_PRI_CPL_LSB+1:`DTS_PRI_CPL_LSB];

  // R6 forcing condition
  wire forceRun = (priType == `DTS_TYPE_LOGIC) ||
                  ((priType == `DTS_TYPE_PULSE) &&
                   ((priCls == `DTS_CLASS_RUNT) || (priCls == `DTS_CLASS_SLEW)));
  // R7 incompatible primary
  wire incompat = forceRun || (priSrc == `DTS_SRC_AUX);
  // R1 effective mode
  wire triggerable = ctrl[`DTS_CTRL_TRIGGERABLE] & ~forceRun;
  // R13 tandem levels
  wire tandem = (srcSel == `DTS_SRC_AUX) && (priSrc == `DTS_SRC_AUX);

  wire        wrEn = psel & penable & pwrite & pready;
  wire        rdEn = psel & penable & ~pwrite & ~pready;
  wire [1:0]  wSub = pwdata[`DTS_CTRL_SUB_LSB+1:`DTS_CTRL_SUB_LSB];
  wire [2:0]  wSrc = pwdata[`DTS_CTRL_SRC_LSB+2:`DTS_CTRL_SRC_LSB];
  wire        wTrig = pwdata[`DTS_CTRL_TRIGGERABLE] | (wSub != `DTS_SUB_NONE);
  wire        mapped = (paddr <= `DTS_CMD_OFF) && (paddr[1:0] == 2'b00);
  wire        srcLevel;
  wire        edgeHit;
  wire signed [15:0] clampLevel;

  // R12 source select
  assign srcLevel = (srcSel == `DTS_SRC_AUX) ? pinSync[4] :
                    (srcSel[2] ? 1'b0 : pinSync[srcSel[1:0]]);

  dts_edge_detect uEdge (
    .clk     (clk),
    .reset_n (reset_n),
    .level   (srcLevel),
    .falling (ctrl[`DTS_CTRL_SLOPE]),
    .edgeHit (edgeHit)
  );

  dts_level_clamp uClamp (
    .levelSel  (ctrl[`DTS_CTRL_LVLSEL_LSB+1:`DTS_CTRL_LVLSEL_LSB]),
    .freeLevel (freeLevel),
    .peakLevel (peakLevel),
    .mvPerDiv  (mvPerDiv),
    .level     (clampLevel)
  );

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pinMeta <= 5'h00;
      pinSync <= 5'h00;
    end else begin
      pinMeta <= {dcAuxiliaryInputPin, channelPin};
      pinSync <= pinMeta;
    end
  end

  // register file
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl       <= `DTS_CTRL_RST;
      delayTime  <= `DTS_DELAY_RST;
      eventCount <= `DTS_EVENTS_RST;
      primary    <= `DTS_PRI_RST;
      freeLevel  <= `DTS_LEVEL_RST;
      primaryLevel <= `DTS_LEVEL_RST;
      mvPerDiv   <= `DTS_MVDIV_RST;
      preLen     <= `DTS_PRE_RST;
      recLen     <= `DTS_TOTAL_RST;
      armPending <= 1'b0;
    end else begin
      armPending <= wrEn && (paddr == `DTS_CMD_OFF) && pwdata[0];
      if (wrEn) begin
        case (paddr)
          `DTS_CTRL_OFF: begin
            ctrl <= pwdata;
            // R10 sub-mode selects triggerable
            // R7 refuse when incompatible
            ctrl[`DTS_CTRL_TRIGGERABLE] <= wTrig & ~incompat;
            if (wSrc > `DTS_SRC_AUX)
              ctrl[`DTS_CTRL_SRC_LSB+2:`DTS_CTRL_SRC_LSB] <= srcSel;
          end
          // R11 independent time and count
          `DTS_DELAY_OFF:   delayTime  <= pwdata;
          `DTS_EVENTS_OFF:  eventCount <= pwdata[15:0];
          `DTS_PRIMARY_OFF: primary    <= pwdata;
          `DTS_LEVEL_OFF: begin
            if (pwdata[16]) begin
              primaryLevel <= pwdata[15:0];
              // R13 primary drags secondary
              if (tandem)
                freeLevel <= pwdata[15:0];
            end else begin
              freeLevel <= pwdata[15:0];
              if (tandem)
                primaryLevel <= pwdata[15:0];
            end
            mvPerDiv <= pwdata[31:20];
          end
          `DTS_RECORD_OFF: begin
            preLen <= pwdata[15:0];
            recLen <= pwdata[31:16];
          end
          default: ;
        endcase
      end else if (forceRun) begin
        // R6 forced back
        ctrl[`DTS_CTRL_TRIGGERABLE] <= 1'b0;
      end
    end
  end

  // apb answer one cycle into access
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      prdata  <= 32'h0000_0000;
      if (rdEn) begin
        case (paddr)
          `DTS_CTRL_OFF:    prdata <= ctrl;
          `DTS_DELAY_OFF:   prdata <= delayTime;
          `DTS_EVENTS_OFF:  prdata <= {16'h0000, eventCount};
          `DTS_PRIMARY_OFF: prdata <= primary;
          `DTS_LEVEL_OFF:   prdata <= {mvPerDiv, 4'h0, secLevel};
          `DTS_RECORD_OFF:  prdata <= {recLen, preLen};
          `DTS_STATUS_OFF:  prdata <= {sampCnt, 8'h00, incompat, triggerable,
                                       recordReady, 2'b00, state};
          `DTS_ZONE_OFF:    prdata <= {zoneEnd[15:0], zoneStart[15:0]};
          default:          prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // sequencer
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state       <= IDLE;
      timer       <= 32'h0000_0000;
      evCnt       <= 16'h0000;
      sampCnt     <= 16'h0000;
      trigAt      <= 32'h0000_0000;
      storeSample <= 1'b0;
      postTrigger <= 1'b0;
      recordReady <= 1'b0;
      acqStart    <= 1'b0;
    end else begin
      acqStart <= 1'b0;
      // R4 pre-trigger storing
      storeSample <= sampleStrobe && (state != IDLE) && (state != DONE);
      case (state)
        IDLE: begin
          postTrigger <= 1'b0;
          if (armPending) begin
            recordReady <= 1'b0;
            state       <= PRE;
          end
        end
        PRE: begin
          if (primaryTrigger) begin
            timer <= 32'h0000_0000;
            evCnt <= 16'h0000;
            // R3 pick the qualifier
            if (!triggerable || subMode == `DTS_SUB_TIME || subMode == `DTS_SUB_NONE)
              state <= TIM;
            else
              state <= CNT;
          end
        end
        CNT: begin
          // R18 count qualified edges
          if (edgeHit) begin
            evCnt <= evCnt + 16'h0001;
            if (evCnt + 16'h0001 >= eventCount) begin
              timer <= 32'h0000_0000;
              if (subMode == `DTS_SUB_EVTIME) begin
                state <= TIM;
              end else begin
                state <= POST;
                acqStart <= 1'b1;
              end
            end
          end
        end
        TIM: begin
          timer <= timer + 32'h0000_0001;
          if (timer + 32'h0000_0001 >= delayTime) begin
            if (triggerable) begin
              // R19 then wait for an edge
              state <= ARM;
            end else begin
              // R2 run after delay
              state <= POST;
              acqStart <= 1'b1;
            end
          end
        end
        ARM: begin
          if (edgeHit) begin
            state    <= POST;
            acqStart <= 1'b1;
          end
        end
        POST: begin
          postTrigger <= 1'b1;
          sampCnt     <= sampleStrobe ? 16'h0001 : 16'h0000;
          state       <= DONE;
        end
        DONE: begin
          // R5 fill remainder then ready
          if (postTrigger) begin
            if (sampleStrobe) begin
              sampCnt <= sampCnt + 16'h0001;
              if (sampCnt + 16'h0001 >= recLen - preLen) begin
                recordReady <= 1'b1;
                state       <= IDLE;
              end
            end
          end else begin
            state <= IDLE;
          end
        end
        default: state <= IDLE;
      endcase
      if (state == DONE && postTrigger && sampleStrobe)
        storeSample <= 1'b1;
      if (state == PRE)
        trigAt <= 32'h0000_0000;
    end
  end

  // zone, secondary trigger outputs
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      zoneStart    <= 32'h0000_0000;
      zoneEnd      <= 32'h0000_0000;
      secSource    <= 3'h0;
      secCoupling  <= `DTS_CPL_DC;
      secLevel     <= `DTS_LEVEL_RST;
    end else begin
      zoneStart <= delayTime - {16'h0000, preLen};
      if (triggerable)
        // R9 zone to record end
        zoneEnd <= 32'hFFFF_FFFF;
      else
        // R8 zone equals secondary record
        zoneEnd <= delayTime - {16'h0000, preLen} + {16'h0000, recLen};
      secSource <= srcSel;
      // R14 coupling follow
      secCoupling <= (cplSel == `DTS_CPL_FOLLOW) ? priCpl : cplSel;
      secLevel    <= tandem ? primaryLevel : clampLevel;
    end
  end
endmodule // dts_sequencer
